// File: verilog/cht_pkg.sv
// Purpose: shared constants and types for the charger decision logic
// Assumes: converter codes are 10-bit fractions of the analog reference
// Notes:   temperature codes follow a 10k/3380 thermistor, 11.5k pull-up
package cht_pkg;
  // ------------------------------------------------------------------
  // clock and time base
  // ------------------------------------------------------------------
  localparam longint CLK_HZ          = 40_000_000;
  localparam longint TICK_S          = 60;   // timer resolution, seconds
  localparam longint TICK_CYCLES_DEF = TICK_S * CLK_HZ;

  // ------------------------------------------------------------------
  // converter code thresholds (code = percent * 1024 / 100)
  // ------------------------------------------------------------------
  localparam logic [9:0] C_HALF  = 10'h200;  // 50%
  localparam logic [9:0] C_P4    = 10'h029;  // 4%
  localparam logic [9:0] C_P5    = 10'h033;  // 5%
  localparam logic [9:0] C_P45   = 10'h1CD;  // 45%
  localparam logic [9:0] C_P55   = 10'h233;  // 55%
  localparam logic [9:0] C_P95   = 10'h3CD;  // 95%
  localparam logic [9:0] C_P96   = 10'h3D7;  // 96%
  localparam logic [9:0] C_GUARD = 10'h004;  // hysteresis half-width
  // thermistor codes; colder reads higher
  localparam logic [9:0] T_M20   = 10'h378;  // -20 C
  localparam logic [9:0] T_M15   = 10'h356;  // -15 C
  localparam logic [9:0] T_0     = 10'h2D8;  // 0 C
  localparam logic [9:0] T_5     = 10'h2A7;  // 5 C
  localparam logic [9:0] T_45    = 10'h132;  // 45 C
  localparam logic [9:0] T_50    = 10'h110;  // 50 C
  localparam logic [9:0] T_25    = 10'h1DC;  // 25 C, neutral duty

  // ------------------------------------------------------------------
  // decode arithmetic (ratio in thousandths, limits in minutes)
  // ------------------------------------------------------------------
  localparam int R_BASE   = 850;
  localparam int R_OFS    = 563_200;    // 0.55 * 1024 * 1000
  localparam int R_SLOPE  = 2734;       // 2.67 * 1024
  localparam int R_TOP    = 2_785_280;  // 2.72 * 1024 * 1000
  localparam int R_MIN    = 860;
  localparam int R_MAX    = 990;
  localparam int L_MIN    = 120;        // 2 hours
  localparam int L_MAX    = 720;        // 12 hours
  localparam int L_NUM    = 375;        // minutes per code = 375/224
  localparam int L_DEN    = 224;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_CONFIG = 8'h08;
  localparam logic [7:0] A_LIMIT  = 8'h0C;
  localparam logic [1:0] CTRL_RST = 2'h2;  // charge enabled, no ps mode
  localparam int         NTIMER   = 3;
  localparam logic [9:0] PWM_MAX  = 10'h3FF;

  typedef enum logic [2:0] {
    ST_ABSENT, ST_S0, ST_S1, ST_S2, ST_S3, ST_DONE, ST_TFAULT
  } cht_state_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] cfgVoltStage;  // config_pin_voltage_stage
    logic [9:0] cfgTimerRange; // config_pin_timer_range
    logic [9:0] thermSense;    // thermistor_sense_input
  } cht_adc_t;

  typedef struct packed {
    logic       compEn;
    logic       stage3En;
    logic       wideRange;
    logic       limitsSet;
    logic [9:0] ratioMilli;
    logic [9:0] comboMin;
  } cht_cfg_t;
endpackage : cht_pkg

// File: verilog/cht_stage_timer.sv
// Purpose: one stage charge timer counting minute ticks
// Assumes: tick is a one-cycle pulse on the same clock
// Notes:   expiry is sticky until clearAll
`timescale 1ns/1ps
module cht_stage_timer (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       run,
  input  wire logic       clearAll,
  input  wire logic [9:0] limit,
  output logic            expired
);
  logic [9:0] count;

  always_ff @(posedge clock) begin
    if (!rst_b || clearAll) begin
      count   <= '0;
      expired <= 1'b0;
    end else if (start && !expired) begin
      count <= '0;
    end else if (run && tick && !expired) begin
      count <= count + 10'h001;
      if (count + 10'h001 >= limit) begin
        expired <= 1'b1;
      end
    end
  end
endmodule : cht_stage_timer

// File: verilog/cht_control.sv
// Purpose: charger configuration decode, temperature and timer logic
// Assumes: converter samples arrive on this clock with a valid strobe
// Notes:   registers reached over APB; stage moves come from outside
//
// Notes on behaviour
// - cfg1 above half enables compensation
// - cfg1 at either rail disables Stage 3
// - cfg1 within 5..95% enables Stage 3
// - compensated ratio from rising cfg1 formula
// - uncompensated ratio from falling cfg1 formula
// - ratio held within 0.86 to 0.99
// - thermistor above 96% means disconnected
// - temperature fault with 5 degree hysteresis
// - fault halts charging, pauses timers
// - feedback pwm duty tracks thermistor reading when compensation is enabled, else fixed at 25 C code
// - absent battery halts; return restarts Stage 0
// - time limits only in power supply mode
// - cfg2 mid band sets stage limits
// - Stage 0 quarter, Stage 3 equal
// - wide range limit decode rising formula
// - narrow range limit decode falling formula
// - ends give 12 hours, centre 2 hours
// - cfg2 beyond 4/96% disables limits
// - cfg2 half selects wide or narrow range
// - timers start on Stage 0,1,3 entry
// - expired timer in its stage stops charging
// - stages 0-2 expiry fault, else done
// - Stage 3 expiry reports done charging
`timescale 1ns/1ps
module cht_control #(
  parameter int unsigned TICK_CYCLES = 32'(cht_pkg::TICK_CYCLES_DEF)
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire cht_pkg::cht_adc_t adc,
  input  wire logic             stageAdvance,
  input  wire logic             stageRevert,
  output logic                  chargeOn,
  output logic                  doneCharging,
  output logic                  timerFault,
  output logic                  tempFault,
  output logic                  batteryAbsent,
  output logic                  output_feedback_adjust_pwm
);
  import cht_pkg::*;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // guard band keeps a noisy pin from chattering across a boundary
  function automatic logic hyst(input logic prev, input logic [9:0] c,
                                input logic [9:0] thr);
    if (c > thr + C_GUARD)      hyst = 1'b1;
    else if (c < thr - C_GUARD) hyst = 1'b0;
    else                        hyst = prev;
  endfunction : hyst

  function automatic logic [9:0] clampTo(input int v, input int lo,
                                         input int hi);
    int r;
    r = v;
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    clampTo = 10'(r);
  endfunction : clampTo

  cht_cfg_t   cfg;
  cht_state_t state;
  cht_state_t prevState;
  logic [1:0] ctrl;        // [0] power supply mode, [1] charge enable
  logic       aboveLow;
  logic       belowHigh;
  logic       bAboveLow;
  logic       bBelowHigh;
  logic       limEn;
  logic [31:0] prescale;
  logic       tick;
  logic [9:0] pwmCount;
  logic [9:0] duty;
  logic [9:0] limits  [NTIMER];
  logic [NTIMER-1:0] starts;
  logic [NTIMER-1:0] runs;
  logic [NTIMER-1:0] expired;
  logic       inStage;
  logic       ownExpired;
  logic [9:0] next_ratio;
  logic [9:0] next_combo;

  // ------------------------------------------------------------------
  // configuration pin decode
  // ------------------------------------------------------------------
  always_comb begin
    if (cfg.compEn) begin
      next_ratio = clampTo(R_BASE + (int'(adc.cfgVoltStage) * 1000
                   - R_OFS) / R_SLOPE, R_MIN, R_MAX);
    end else begin
      next_ratio = clampTo((R_TOP - int'(adc.cfgVoltStage) * 1000)
                   / R_SLOPE, R_MIN, R_MAX);
    end
    if (cfg.wideRange) begin
      next_combo = clampTo(L_MIN + (int'(adc.cfgTimerRange)
                   - int'(C_P55)) * L_NUM / L_DEN, L_MIN, L_MAX);
    end else begin
      next_combo = clampTo(L_MIN + (int'(C_P45)
                   - int'(adc.cfgTimerRange)) * L_NUM / L_DEN,
                   L_MIN, L_MAX);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cfg        <= '0;
      aboveLow   <= 1'b0;
      belowHigh  <= 1'b1;
      bAboveLow  <= 1'b0;
      bBelowHigh <= 1'b1;
    end else if (adc.valid) begin
      cfg.compEn    <= hyst(cfg.compEn, adc.cfgVoltStage, C_HALF);
      aboveLow      <= hyst(aboveLow, adc.cfgVoltStage, C_P5);
      belowHigh     <= !hyst(!belowHigh, adc.cfgVoltStage, C_P95);
      cfg.stage3En  <= aboveLow && belowHigh;
      cfg.wideRange <= hyst(cfg.wideRange, adc.cfgTimerRange,
                            C_HALF);
      bAboveLow     <= hyst(bAboveLow, adc.cfgTimerRange, C_P4);
      bBelowHigh    <= !hyst(!bBelowHigh, adc.cfgTimerRange, C_P96);
      cfg.limitsSet <= bAboveLow && bBelowHigh;
      cfg.ratioMilli <= next_ratio;
      cfg.comboMin   <= next_combo;
    end
  end

  assign limEn = cfg.limitsSet && ctrl[0];

  // ------------------------------------------------------------------
  // thermistor supervision
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      batteryAbsent <= 1'b1;
    end else if (adc.valid) begin
      batteryAbsent <= hyst(batteryAbsent, adc.thermSense, C_P96);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tempFault <= 1'b0;
    end else if (adc.valid) begin
      if (batteryAbsent) begin
        tempFault <= 1'b0;
      end else if (!tempFault) begin
        tempFault <= adc.thermSense < T_50 ||
                     adc.thermSense > (cfg.wideRange ? T_M20 : T_0);
      end else begin
        tempFault <= !(adc.thermSense > T_45 &&
                     adc.thermSense < (cfg.wideRange ? T_M15 : T_5));
      end
    end
  end

  // ------------------------------------------------------------------
  // feedback adjust pwm
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      duty <= T_25;
    end else if (adc.valid) begin
      duty <= cfg.compEn ? adc.thermSense : T_25;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pwmCount                   <= '0;
      output_feedback_adjust_pwm <= 1'b0;
    end else begin
      pwmCount <= (pwmCount == PWM_MAX) ? '0 : pwmCount + 10'h001;
      output_feedback_adjust_pwm <= pwmCount < duty;
    end
  end

  // ------------------------------------------------------------------
  // stage timers
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prescale <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= prescale == TICK_CYCLES - 1;
      prescale <= (prescale == TICK_CYCLES - 1) ? '0 : prescale + 32'h1;
    end
  end

  assign limits[0] = {2'h0, cfg.comboMin[9:2]};
  assign limits[1] = cfg.comboMin;
  assign limits[2] = cfg.comboMin;
  assign starts[0] = state == ST_S0 && prevState != ST_S0;
  assign starts[1] = state == ST_S1 && prevState != ST_S1 &&
                     prevState != ST_S2;
  assign starts[2] = state == ST_S3 && prevState != ST_S3;
  assign runs[0]   = state == ST_S0;
  assign runs[1]   = state == ST_S1 || state == ST_S2;
  assign runs[2]   = state == ST_S3;

  generate
    for (genvar i = 0; i < NTIMER; i++) begin : gTimer
      cht_stage_timer uTimer (
        .clock    (clock),
        .rst_b    (rst_b),
        .tick     (tick),
        .start    (starts[i]),
        .run      (runs[i] && limEn && !tempFault),
        .clearAll (batteryAbsent || !limEn),
        .limit    (limits[i]),
        .expired  (expired[i])
      );
    end
  endgenerate

  assign ownExpired = limEn && |(expired & runs);

  // ------------------------------------------------------------------
  // stage sequence
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state     <= ST_ABSENT;
      prevState <= ST_ABSENT;
    end else begin
      prevState <= state;
      if (batteryAbsent) begin
        state <= ST_ABSENT;
      end else begin
        case (state)
          ST_ABSENT: state <= ST_S0;
          ST_S0, ST_S1, ST_S2, ST_S3: begin
            if (ownExpired) begin
              state <= (state == ST_S3) ? ST_DONE : ST_TFAULT;
            end else if (tempFault) begin
              state <= state;
            end else if (stageRevert) begin
              state <= ST_S0;
            end else if (stageAdvance) begin
              case (state)
                ST_S0: state <= ST_S1;
                ST_S1: state <= ST_S2;
                ST_S2: begin
                  if (cfg.stage3En) state <= ST_S3;
                  else if (limEn)   state <= ST_DONE;
                  else              state <= ST_S2;
                end
                default: state <= state;
              endcase
            end
          end
          ST_DONE, ST_TFAULT: state <= state;
          default: state <= ST_ABSENT;
        endcase
      end
    end
  end

  assign inStage = state inside {ST_S0, ST_S1, ST_S2, ST_S3};

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      chargeOn     <= 1'b0;
      doneCharging <= 1'b0;
      timerFault   <= 1'b0;
    end else begin
      chargeOn <= inStage && !ownExpired && !tempFault &&
                  !batteryAbsent && ctrl[1];
      doneCharging <= state == ST_DONE;
      timerFault   <= state == ST_TFAULT;
    end
  end

  // ------------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
    end else if (psel && penable && pready && pwrite &&
                 paddr == A_CTRL) begin
      ctrl <= pwdata[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        case (paddr)
          A_CTRL:   prdata <= {30'h0, ctrl};
          A_STATUS: prdata <= {24'h0, batteryAbsent, tempFault,
                               timerFault, doneCharging, chargeOn,
                               3'(state)};
          A_CONFIG: prdata <= {12'h0, cfg.ratioMilli, 5'h0, limEn,
                               cfg.limitsSet, cfg.wideRange,
                               cfg.stage3En, cfg.compEn};
          A_LIMIT:  prdata <= {22'h0, cfg.comboMin};
          default:  pslverr <= 1'b1;
        endcase
        if (pwrite && paddr != A_CTRL) begin
          pslverr <= paddr != A_STATUS && paddr != A_CONFIG &&
                     paddr != A_LIMIT;
        end
      end
    end
  end
endmodule : cht_control

// File: testbench/cht_sense_model.sv
// Purpose: divider and thermistor model feeding converter samples
// Assumes: bench sets each pin level as a code of the analog reference
// Notes:   one sample every 8 clocks, so decode waits span several
`timescale 1ns/1ps
module cht_sense_model (
  input  wire logic         clock,
  input  wire logic [9:0]   cfgV,
  input  wire logic [9:0]   cfgT,
  input  wire logic [9:0]   therm,
  output cht_pkg::cht_adc_t adc
);
  import cht_pkg::*;
  logic [2:0] phase = 3'h0;
  always_ff @(posedge clock) begin
    phase <= phase + 3'h1;
    adc   <= '{(phase == 3'h7), cfgV, cfgT, therm};
  end
endmodule : cht_sense_model

// File: testbench/cht_control_monitor.sv
// Purpose: port checks on the charger control block
// Assumes: one clock, synchronous active-low reset
// Notes:   halt checks allow two edges of state and output lag
`timescale 1ns/1ps
module cht_control_monitor (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire cht_pkg::cht_adc_t adc,
  input wire logic              chargeOn,
  input wire logic              doneCharging,
  input wire logic              timerFault,
  input wire logic              tempFault,
  input wire logic              batteryAbsent
);
  import cht_pkg::*;
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_absent_detect: assert property (
    adc.valid && adc.thermSense > 10'h3DB |=> batteryAbsent)
    else $error("open thermistor not seen");
  a_present_detect: assert property (
    adc.valid && adc.thermSense <= 10'h3D3 |=> !batteryAbsent)
    else $error("battery present not seen");
  a_hot_fault: assert property (
    adc.valid && adc.thermSense < T_50 |=> tempFault)
    else $error("hot battery not faulted");
  a_fault_band: assert property (
    tempFault && adc.valid && adc.thermSense inside {[T_50:T_45]}
    |=> tempFault)
    else $error("fault cleared inside hysteresis");
  a_fault_halts: assert property (tempFault [*3] |-> !chargeOn)
    else $error("charging during temperature fault");
  a_absent_halts: assert property (batteryAbsent [*3] |-> !chargeOn)
    else $error("charging without battery");
  a_expiry_halts: assert property (timerFault [*3] |-> !chargeOn)
    else $error("charging after timer fault");
  a_done_clean: assert property (
    doneCharging [*3] |-> !chargeOn && !timerFault)
    else $error("done state charging or faulted");
endmodule : cht_control_monitor

bind cht_control cht_control_monitor u_mon (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .adc(adc), .chargeOn(chargeOn),
  .doneCharging(doneCharging), .timerFault(timerFault),
  .tempFault(tempFault), .batteryAbsent(batteryAbsent));

// File: testbench/cht_control_test.sv
// Purpose: self-checking bench for the charger control block
// Assumes: minute tick shortened to 4 clocks
// Notes:   stage moves driven by hand, charging loops not modelled
`timescale 1ns/1ps
module cht_control_test;
  import cht_pkg::*;
  logic              clock = 1'b0;
  logic              rst_b = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic              stageAdvance = 1'b0;
  logic              stageRevert = 1'b0;
  logic [9:0]        cfgV = 10'h000;
  logic [9:0]        cfgT = 10'h000;
  logic [9:0]        therm = 10'h3FF;
  logic [31:0]       prdata, rdData;
  logic              pready, pslverr, rdErr, pwm;
  logic              chargeOn, doneCharging, timerFault, tempFault;
  logic              batteryAbsent;
  cht_adc_t          adc;
  int                errCount = 0;
  int                nChecks = 0;

  initial begin
    forever #12.5 clock = ~clock;
  end
  cht_sense_model sense (.clock(clock), .cfgV(cfgV), .cfgT(cfgT),
    .therm(therm), .adc(adc));
  cht_control #(.TICK_CYCLES(4)) uut (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .adc(adc),
    .stageAdvance(stageAdvance), .stageRevert(stageRevert),
    .chargeOn(chargeOn), .doneCharging(doneCharging),
    .timerFault(timerFault), .tempFault(tempFault),
    .batteryAbsent(batteryAbsent), .output_feedback_adjust_pwm(pwm));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [31:0] seen, exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      errCount++;
      finish_test();
    end
  endtask : apb
  task automatic settle;
    repeat (40) @(posedge clock);
  endtask : settle
  task automatic cfg_case(input logic [9:0] v, t,
                          input logic [31:0] exp, msk, lim);
    @(posedge clock);
    cfgV <= v;
    cfgT <= t;
    settle();
    apb(1'b0, A_CONFIG, 32'h0);
    chk("config", rdData & msk, exp);
    if (lim != 32'h0) begin
      apb(1'b0, A_LIMIT, 32'h0);
      chk("limit", rdData & 32'h3FF, lim);
    end
  endtask : cfg_case
  task automatic temp_step(input logic [9:0] c, input logic f);
    @(posedge clock);
    therm <= c;
    settle();
    apb(1'b0, A_STATUS, 32'h0);
    chk("temp fault", {31'h0, rdData[6]}, {31'h0, f});
    if (f) chk("halted", {31'h0, rdData[3]}, 32'h0);
  endtask : temp_step
  task automatic step(input logic rev);
    @(posedge clock);
    stageAdvance <= ~rev;
    stageRevert <= rev;
    @(posedge clock);
    stageAdvance <= 1'b0;
    stageRevert <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : step
  task automatic replug;
    temp_step(10'h3FF, 1'b0);
    chk("absent", {31'h0, rdData[7]}, 32'h1);
    temp_step(T_25, 1'b0);
  endtask : replug
  task automatic poll(input int b);
    int n;
    for (n = 0; n < 400; n++) begin
      apb(1'b0, A_STATUS, 32'h0);
      if (rdData[b] === 1'b1) break;
    end
    if (n == 400) begin
      errCount++;
      finish_test();
    end
  endtask : poll
  task automatic duty(input logic [9:0] exp);
    int hi;
    hi = 0;
    settle();
    repeat (1024) begin
      @(posedge clock);
      hi += pwm;
    end
    chk("pwm duty", 32'(hi), {22'h0, exp});
  endtask : duty

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl reset", rdData, 32'h2);
    apb(1'b0, A_STATUS, 32'h0);
    chk("status reset", rdData & 32'hFF, 32'h80);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", {31'h0, rdErr}, 32'h1);
    chk("unmapped data", rdData, 32'h0);
    apb(1'b1, A_CTRL, 32'h3);
    cfg_case(10'h3C0, 10'h3B3, 32'hF781F, 32'hFFC1F, 32'h2D0);
    cfg_case(10'h040, 10'h04C, 32'hF781A, 32'hFFC1F, 32'h2D0);
    cfg_case(10'h234, 10'h230, 32'hD701F, 32'hFFC1F, 32'h078);
    cfg_case(10'h1CC, 10'h1D0, 32'hD701A, 32'hFFC1F, 32'h078);
    cfg_case(10'h3FF, 10'h3FF, 32'h00005, 32'h0001F, 32'h0);
    apb(1'b1, A_CTRL, 32'h2);
    cfg_case(10'h3C0, 10'h3B3, 32'hF780F, 32'hFFC1F, 32'h0);
    cfg_case(10'h000, 10'h000, 32'h00000, 32'h0001F, 32'h0);
    replug();
    chk("stage 0", rdData & 32'hF, 32'h9);
    step(1'b0);
    apb(1'b0, A_STATUS, 32'h0);
    chk("stage 1", rdData & 32'h7, 32'h2);
    step(1'b1);
    apb(1'b0, A_STATUS, 32'h0);
    chk("revert", rdData & 32'h7, 32'h1);
    temp_step(10'h2E0, 1'b1);
    temp_step(10'h2C0, 1'b1);
    temp_step(T_25, 1'b0);
    temp_step(10'h100, 1'b1);
    temp_step(10'h120, 1'b1);
    temp_step(T_25, 1'b0);
    cfgT <= 10'h3FF;
    temp_step(10'h2E0, 1'b0);
    temp_step(10'h380, 1'b1);
    temp_step(T_25, 1'b0);
    duty(T_25);
    cfgV <= 10'h3FF;
    therm <= 10'h180;
    duty(10'h180);
    apb(1'b1, A_CTRL, 32'h3);
    cfgV <= 10'h3C0;
    cfgT <= 10'h1D0;
    replug();
    poll(5);
    chk("s0 expiry", rdData & 32'h38, 32'h20);
    replug();
    step(1'b0);
    step(1'b0);
    step(1'b0);
    apb(1'b0, A_STATUS, 32'h0);
    chk("stage 3", rdData & 32'h7, 32'h4);
    poll(4);
    chk("s3 expiry", rdData & 32'h38, 32'h10);
    finish_test();
  end
endmodule : cht_control_test
